// ### pps_pkg.sv
/*
  Package for the position pulse sequencer: mode codes, status bit
  positions, link widths, frame limits, host register offsets.
  Assumes both ends and the link interface import it.
*/
`default_nettype none
package pps_pkg;
  // Link and datapath widths
  localparam int PPS_POS_W = 32;
  localparam int PPS_WIDTH_W = 16;
  localparam int PPS_IDX_W = 7;
  localparam int PPS_CNT_W = 8;
  localparam int PPS_MAX_FRAMES = 128;
  localparam int PPS_STATUS_W = 16;

  // Sequencer mode codes; all others are reserved
  localparam logic [2:0] PPS_MODE_NULL = 3'h0;
  localparam logic [2:0] PPS_MODE_SETUP = 3'h1;
  localparam logic [2:0] PPS_MODE_LOAD = 3'h5;
  localparam logic [2:0] PPS_MODE_RUN = 3'h6;

  // Status word bit positions
  localparam int PPS_ST_COUNT_LSB = 0;
  localparam int PPS_ST_ENABLED = 8;
  localparam int PPS_ST_ARMED = 9;
  localparam int PPS_ST_DIR = 10;
  localparam int PPS_ST_DONE = 11;
  localparam int PPS_ST_AUTO = 12;
  localparam int PPS_ST_BUSY = 13;

  // Host register byte offsets
  localparam logic [7:0] PPS_REG_MODE = 8'h00;
  localparam logic [7:0] PPS_REG_WIDTH = 8'h04;
  localparam logic [7:0] PPS_REG_INTERVAL = 8'h08;
  localparam logic [7:0] PPS_REG_CONFIG = 8'h0C;
  localparam logic [7:0] PPS_REG_COUNT = 8'h10;
  localparam logic [7:0] PPS_REG_INDEX = 8'h14;
  localparam logic [7:0] PPS_REG_DATA = 8'h18;
  localparam logic [7:0] PPS_REG_STATUS = 8'hDC;
  localparam int PPS_CFG_AUTO_BIT = 0;

  // Reset values
  localparam logic [PPS_WIDTH_W-1:0] PPS_WIDTH_RST = 16'h0001;
  localparam logic [PPS_POS_W-1:0] PPS_INTERVAL_RST = 32'h00000001;

  typedef enum logic [2:0] {
    PPS_ST_IDLE,
    PPS_ST_INIT,
    PPS_ST_WAIT_ARM,
    PPS_ST_FIRE,
    PPS_ST_FINISHED
  } pps_seq_state_type;
endpackage : pps_pkg
`default_nettype wire

// ### pps_link_if.sv
/*
  Link between drive processor end and sequencer end.
  Assumes one shared clock; both ends drive only their modport outputs.
*/
`timescale 1ns/10ps
`default_nettype none
interface pps_link_if;
  import pps_pkg::*;
  logic [2:0] mode;
  logic [PPS_WIDTH_W-1:0] pulse_width;
  logic [PPS_POS_W-1:0] interval;
  logic auto_repeat_bit;
  logic [PPS_CNT_W-1:0] frame_count;
  logic frm_req;
  logic [PPS_IDX_W-1:0] frm_idx;
  logic frm_valid;
  logic signed [PPS_POS_W-1:0] frm_start;
  logic signed [PPS_POS_W-1:0] frm_stop;
  logic [PPS_STATUS_W-1:0] status;

  modport host (
    output mode, pulse_width, interval, auto_repeat_bit, frame_count,
    output frm_valid, frm_start, frm_stop,
    input frm_req, frm_idx, status
  );
  modport dev (
    input mode, pulse_width, interval, auto_repeat_bit, frame_count,
    input frm_valid, frm_start, frm_stop,
    output frm_req, frm_idx, status
  );
endinterface : pps_link_if
`default_nettype wire

// ### pps_sequencer.sv
/*
  Sequencer end: holds the frame list, arms on absolute position and
  fires pulses at interval steps between start and stop of each frame.
  Assumes the position and PWM tick come from logic on i_clk.
*/
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module pps_sequencer
  import pps_pkg::*;
#(
  parameter int MAX_FRAMES = PPS_MAX_FRAMES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Motion side
  input wire logic signed [PPS_POS_W-1:0] i_abs_pos,
  input wire logic i_pwm_tick,
  output logic o_pulse,
  output logic [PPS_STATUS_W-1:0] o_status,
  // Link to drive processor
  pps_link_if.dev link
);
  logic signed [PPS_POS_W-1:0] start_mem [MAX_FRAMES];
  logic signed [PPS_POS_W-1:0] stop_mem [MAX_FRAMES];

  logic [2:0] mode_prev_q;
  logic [PPS_WIDTH_W-1:0] width_q;
  logic [PPS_POS_W-1:0] interval_q;
  logic auto_q;
  logic [PPS_CNT_W-1:0] count_q;
  logic [PPS_CNT_W-1:0] loaded_q;
  logic busy_q;
  logic req_q;
  logic [PPS_IDX_W-1:0] load_idx_q;
  pps_seq_state_type state_q;
  logic [PPS_IDX_W-1:0] frame_q;
  logic signed [PPS_POS_W-1:0] trig_q;
  logic dir_q;
  logic armed_q;
  logic done_q;
  logic pulse_q;
  logic [PPS_WIDTH_W-1:0] pulse_cnt_q;
  logic [PPS_STATUS_W-1:0] status_q;

  logic load_entry;
  logic run_mode;
  logic signed [PPS_POS_W-1:0] cur_start;
  logic signed [PPS_POS_W-1:0] cur_stop;
  logic fire;

  // Signed compare in frame direction: pos is ahead of ref
  function automatic logic beyond(input logic dir, input logic signed [PPS_POS_W-1:0] pos,
                                  input logic signed [PPS_POS_W-1:0] ref_pos);
    beyond = dir ? (pos > ref_pos) : (pos < ref_pos);
  endfunction : beyond

  function automatic logic reached(input logic dir, input logic signed [PPS_POS_W-1:0] pos,
                                   input logic signed [PPS_POS_W-1:0] ref_pos);
    reached = dir ? (pos >= ref_pos) : (pos <= ref_pos);
  endfunction : reached

  assign load_entry = (link.mode == PPS_MODE_LOAD) && (mode_prev_q != PPS_MODE_LOAD);
  assign run_mode = (link.mode == PPS_MODE_RUN);
  assign cur_start = start_mem[frame_q];
  assign cur_stop = stop_mem[frame_q];
  assign fire = (state_q == PPS_ST_FIRE) && run_mode && !beyond(dir_q, i_abs_pos, cur_stop)
                && reached(dir_q, i_abs_pos, trig_q);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_prev_q <= PPS_MODE_NULL;
    end else begin
      mode_prev_q <= link.mode;
    end
  end

  // Setup values only cross while setup mode is selected
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      width_q <= PPS_WIDTH_RST;
      interval_q <= PPS_INTERVAL_RST;
      auto_q <= 1'b0;
    end else if (link.mode == PPS_MODE_SETUP) begin
      width_q <= link.pulse_width;
      interval_q <= link.interval;
      auto_q <= link.auto_repeat_bit;
    end
  end

  // Frame download: one request per PWM tick, answer one clock later
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_q <= '0;
      loaded_q <= '0;
      busy_q <= 1'b0;
      req_q <= 1'b0;
      load_idx_q <= '0;
    end else if (load_entry) begin
      count_q <= link.frame_count;
      loaded_q <= '0;
      busy_q <= (link.frame_count != '0);
      req_q <= 1'b0;
      load_idx_q <= '0;
    end else begin
      req_q <= busy_q && i_pwm_tick && !req_q;
      if (busy_q && link.frm_valid) begin
        loaded_q <= loaded_q + 8'h01;
        load_idx_q <= load_idx_q + 7'h01;
        if ({1'b0, load_idx_q} + 8'h01 >= count_q) begin
          busy_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (busy_q && link.frm_valid) begin
      start_mem[load_idx_q] <= link.frm_start;
      stop_mem[load_idx_q] <= link.frm_stop;
    end
  end

  // Sequencer; frame index survives leaving run so a run resumes; entry to load clears it
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= PPS_ST_IDLE;
      frame_q <= '0;
      trig_q <= '0;
      dir_q <= 1'b0;
      armed_q <= 1'b0;
      done_q <= 1'b0;
    end else if (load_entry) begin
      state_q <= PPS_ST_IDLE;
      frame_q <= '0;
      armed_q <= 1'b0;
      done_q <= 1'b0;
    end else if (!run_mode) begin
      state_q <= PPS_ST_IDLE;
      armed_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      case (state_q)
        PPS_ST_IDLE: begin
          state_q <= PPS_ST_INIT;
        end
        PPS_ST_INIT: begin
          if (loaded_q == '0) begin
            done_q <= 1'b1;
            state_q <= PPS_ST_FINISHED;
          end else begin
            trig_q <= cur_start;
            dir_q <= (cur_stop > cur_start);
            armed_q <= 1'b0;
            state_q <= PPS_ST_WAIT_ARM;
          end
        end
        PPS_ST_WAIT_ARM: begin
          if (beyond(!dir_q, i_abs_pos, cur_start)) begin
            armed_q <= 1'b1;
            state_q <= PPS_ST_FIRE;
          end
        end
        PPS_ST_FIRE: begin
          if (beyond(dir_q, i_abs_pos, cur_stop)) begin
            armed_q <= 1'b0;
            if ({1'b0, frame_q} + 8'h01 >= loaded_q) begin
              frame_q <= '0;
              if (auto_q) begin
                state_q <= PPS_ST_INIT;
              end else begin
                done_q <= 1'b1;
                state_q <= PPS_ST_FINISHED;
              end
            end else begin
              frame_q <= frame_q + 7'h01;
              state_q <= PPS_ST_INIT;
            end
          end else if (beyond(!dir_q, i_abs_pos, cur_start)) begin
            trig_q <= cur_start;
          end else if (fire) begin
            trig_q <= dir_q ? trig_q + interval_q : trig_q - interval_q;
          end
        end
        PPS_ST_FINISHED: begin
          state_q <= PPS_ST_FINISHED;
        end
        default: begin
          state_q <= PPS_ST_IDLE;
        end
      endcase
    end
  end

  // Pulse stretcher; a width of zero gives no pulse
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pulse_q <= 1'b0;
      pulse_cnt_q <= '0;
    end else if (fire) begin
      pulse_q <= (width_q != '0);
      pulse_cnt_q <= width_q;
    end else begin
      pulse_q <= (pulse_cnt_q > 16'h0001);
      pulse_cnt_q <= (pulse_cnt_q != '0) ? pulse_cnt_q - 16'h0001 : '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      status_q <= '0;
    end else begin
      status_q <= '0;
      status_q[PPS_ST_COUNT_LSB +: PPS_CNT_W] <= loaded_q;
      status_q[PPS_ST_ENABLED] <= run_mode && !done_q;
      status_q[PPS_ST_ARMED] <= armed_q;
      status_q[PPS_ST_DIR] <= dir_q;
      status_q[PPS_ST_DONE] <= done_q;
      status_q[PPS_ST_AUTO] <= auto_q;
      status_q[PPS_ST_BUSY] <= busy_q || load_entry;
    end
  end

  assign o_pulse = pulse_q;
  assign o_status = status_q;
  assign link.status = status_q;
  assign link.frm_req = req_q;
  assign link.frm_idx = load_idx_q;
endmodule : pps_sequencer
`default_nettype wire

// ### pps_drive_host.sv
/*
  Drive processor end: software registers, frame list store with
  auto-incrementing index, answers frame requests from the sequencer.
  Assumes software uses the plain strobe port on i_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module pps_drive_host
  import pps_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Software register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Link to sequencer
  pps_link_if.host link
);
  localparam int DATA_WORDS = 2 * PPS_MAX_FRAMES;

  logic [31:0] data_mem [DATA_WORDS];
  logic [2:0] mode_q;
  logic [PPS_WIDTH_W-1:0] width_q;
  logic [PPS_POS_W-1:0] interval_q;
  logic auto_q;
  logic [PPS_CNT_W-1:0] count_q;
  logic [7:0] index_q;
  logic [31:0] rdata_q;
  logic valid_q;
  logic [31:0] start_q;
  logic [31:0] stop_q;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_q <= PPS_MODE_NULL;
      width_q <= PPS_WIDTH_RST;
      interval_q <= PPS_INTERVAL_RST;
      auto_q <= 1'b0;
      count_q <= '0;
    end else if (i_wr) begin
      case (i_addr)
        PPS_REG_MODE: begin
          if (!link.status[PPS_ST_BUSY]) begin
            mode_q <= i_wdata[2:0];
          end
        end
        PPS_REG_WIDTH: width_q <= i_wdata[PPS_WIDTH_W-1:0];
        PPS_REG_INTERVAL: interval_q <= i_wdata;
        PPS_REG_CONFIG: auto_q <= i_wdata[PPS_CFG_AUTO_BIT];
        PPS_REG_COUNT: count_q <= i_wdata[PPS_CNT_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Index steps after each data access, read or write
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      index_q <= '0;
    end else if (i_wr && i_addr == PPS_REG_INDEX) begin
      index_q <= i_wdata[7:0];
    end else if ((i_wr || i_rd) && i_addr == PPS_REG_DATA) begin
      index_q <= index_q + 8'h01;
    end
  end

  // Store may change during a run; the sequencer keeps its own copy
  always_ff @(posedge i_clk) begin
    if (i_wr && i_addr == PPS_REG_DATA) begin
      data_mem[index_q] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= '0;
      if (i_rd) begin
        case (i_addr)
          PPS_REG_MODE: rdata_q <= {29'h0, mode_q};
          PPS_REG_WIDTH: rdata_q <= {16'h0, width_q};
          PPS_REG_INTERVAL: rdata_q <= interval_q;
          PPS_REG_CONFIG: rdata_q <= {31'h0, auto_q};
          PPS_REG_COUNT: rdata_q <= {24'h0, count_q};
          PPS_REG_INDEX: rdata_q <= {24'h0, index_q};
          PPS_REG_DATA: rdata_q <= data_mem[index_q];
          PPS_REG_STATUS: rdata_q <= {16'h0, link.status};
          default: rdata_q <= '0;
        endcase
      end
    end
  end

  // Frame answer one clock after the request
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      valid_q <= 1'b0;
      start_q <= '0;
      stop_q <= '0;
    end else begin
      valid_q <= link.frm_req;
      if (link.frm_req) begin
        start_q <= data_mem[{link.frm_idx, 1'b0}];
        stop_q <= data_mem[{link.frm_idx, 1'b1}];
      end
    end
  end

  assign o_rdata = rdata_q;
  assign link.mode = mode_q;
  assign link.pulse_width = width_q;
  assign link.interval = interval_q;
  assign link.auto_repeat_bit = auto_q;
  assign link.frame_count = count_q;
  assign link.frm_valid = valid_q;
  assign link.frm_start = start_q;
  assign link.frm_stop = stop_q;
endmodule : pps_drive_host
`default_nettype wire

// ### pps_props.sv
/*
  Checker for the link between host end and sequencer end.
  Assumes one clock and the link signals wired in as plain inputs.
*/
`timescale 1ns/10ps
`default_nettype none
module pps_props
  import pps_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Link signals
  input wire logic [2:0] mode,
  input wire logic frm_req,
  input wire logic [PPS_IDX_W-1:0] frm_idx,
  input wire logic frm_valid,
  input wire logic [PPS_STATUS_W-1:0] status
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  chk_req_answer: assert property (frm_req |=> frm_valid && $stable(frm_idx))
    else $error("frame answer missing");
  chk_req_load: assert property (frm_req |-> mode == PPS_MODE_LOAD)
    else $error("frame request outside load");
  chk_busy_mode: assert property (status[13] |-> mode == PPS_MODE_LOAD && !status[8])
    else $error("mode moved during download");
  chk_done_idle: assert property (status[11] |-> !status[8] && !status[9])
    else $error("done while enabled");
  chk_done_hold: assert property ($past(status[11]) && mode == PPS_MODE_RUN && $past(mode) == PPS_MODE_RUN
      && $past(mode, 2) == PPS_MODE_RUN |-> status[11])
    else $error("done dropped in run");
  chk_en_run: assert property (status[8] |-> $past(mode) == PPS_MODE_RUN || $past(mode, 2) == PPS_MODE_RUN
      || $past(mode, 3) == PPS_MODE_RUN)
    else $error("enabled outside run");
  chk_auto_held: assert property ((mode != PPS_MODE_SETUP)[*3] |-> $stable(status[12]))
    else $error("auto copy moved outside setup");
  chk_load_undone: assert property (mode == PPS_MODE_LOAD && $past(mode) != PPS_MODE_LOAD
      |-> ##[1:3] !status[11])
    else $error("load did not clear done");
  chk_rsvd_zero: assert property (status[15:14] == 2'h0)
    else $error("reserved status bits set");

  cov_answer: cover property (frm_valid);
  cov_busy: cover property ($rose(status[13]));
  cov_armed: cover property (status[9]);
  cov_done: cover property (status[11]);
endmodule : pps_props
`default_nettype wire

// ### position_pulse_sequencer_test.sv
/*
  Testbench: host end and sequencer end joined by the link.
  Assumes registers via the strobe port; pulses counted at o_pulse.
*/
`timescale 1ns/10ps
`default_nettype none
module position_pulse_sequencer_test;
  import pps_pkg::*;
  typedef struct {logic signed [31:0] s, e; logic dir; int n;} pps_row_type;
  pps_row_type rows[4] = '{'{100, 120, 1, 6}, '{200, 180, 0, 6}, '{-50, -41, 1, 3}, '{10, 12, 1, 1}};
  logic [31:0] rsv[4] = '{32'h2, 32'h3, 32'h4, 32'h7};
  logic i_clk = 0, i_reset_n = 0, i_wr = 0, i_rd = 0, i_pwm_tick = 0, o_pulse, pprev = 0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, st, st0;
  logic [15:0] o_status;
  logic signed [31:0] pos = 32'sh0, fs[2], fe[2];
  int error_cnt = 0, comparisons = 0, cyc = 0, npul = 0, nhigh = 0;

  pps_link_if link();
  pps_sequencer pps_sequencer_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_abs_pos(pos),
    .i_pwm_tick(i_pwm_tick), .o_pulse(o_pulse), .o_status(o_status), .link(link));
  pps_drive_host pps_drive_host_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .link(link));
  pps_props pps_props_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .mode(link.mode),
    .frm_req(link.frm_req), .frm_idx(link.frm_idx), .frm_valid(link.frm_valid), .status(link.status));

  always #2 i_clk = ~i_clk;

  // Pulse edges and high cycles; ceiling cuts a hang short
  always @(posedge i_clk) begin
    cyc++;
    pprev <= o_pulse;
    if (o_pulse && !pprev) npul++;
    if (o_pulse) nhigh++;
    if (cyc > 40000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    st = o_rdata;
  endtask : rd

  task automatic load(input int n, input bit refuse);
    wr(PPS_REG_COUNT, 32'(n));
    wr(PPS_REG_INDEX, 32'h0);
    for (int i = 0; i < n; i++) begin
      wr(PPS_REG_DATA, fs[i]);
      wr(PPS_REG_DATA, fe[i]);
    end
    wr(PPS_REG_MODE, 32'(PPS_MODE_LOAD));
    repeat (3) @(posedge i_clk);
    // Run request while busy must be dropped
    if (refuse) begin
      wr(PPS_REG_MODE, 32'(PPS_MODE_RUN));
      // Look past the taking edge, else a taken write would still read as load
      #1;
      chk("mode held", 32'(PPS_MODE_LOAD), 32'(link.mode));
    end
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk);
      i_pwm_tick <= 1'b1;
      @(posedge i_clk);
      i_pwm_tick <= 1'b0;
      repeat (4) @(posedge i_clk);
      rd(PPS_REG_STATUS);
      chk("loaded", 32'(i + 1), 32'(st[7:0]));
      chk("busy", 32'(i < n - 1), 32'(st[13]));
    end
  endtask : load

  task automatic go(input logic signed [31:0] t);
    int k;
    k = pos;
    while (k != t) begin
      k += (k < t) ? 1 : -1;
      @(posedge i_clk);
      pos <= k;
    end
  endtask : go

  task automatic run(input logic signed [31:0] from, input logic signed [31:0] to, input int n);
    @(posedge i_clk);
    pos <= from;
    wr(PPS_REG_MODE, 32'(PPS_MODE_RUN));
    repeat (4) @(posedge i_clk);
    rd(PPS_REG_STATUS);
    st0 = st;
    npul = 0;
    nhigh = 0;
    go(to);
    repeat (6) @(posedge i_clk);
    chk("pulses", 32'(n), 32'(npul));
    chk("high cycles", 32'(2 * n), 32'(nhigh));
  endtask : run

  initial begin
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd(PPS_REG_STATUS);
    chk("status reset", 32'h0, st);
    rd(8'hF0);
    chk("unmapped", 32'h0, st);
    wr(PPS_REG_WIDTH, 32'h2);
    wr(PPS_REG_INTERVAL, 32'h4);
    wr(PPS_REG_CONFIG, 32'h0);
    wr(PPS_REG_MODE, 32'(PPS_MODE_SETUP));
    repeat (3) @(posedge i_clk);
    foreach (rsv[i]) begin
      wr(PPS_REG_MODE, rsv[i]);
      repeat (3) @(posedge i_clk);
      rd(PPS_REG_STATUS);
      chk("reserved enabled", 32'h0, 32'(st[8]));
    end
    foreach (rows[r]) begin
      fs[0] = rows[r].s;
      fe[0] = rows[r].e;
      load(1, 1'b0);
      run(rows[r].dir ? rows[r].s - 3 : rows[r].s + 3, rows[r].dir ? rows[r].e + 3 : rows[r].e - 3, rows[r].n);
      chk("direction", 32'(rows[r].dir), 32'(st0[10]));
      chk("armed", 32'h1, 32'(st0[9]));
      chk("enabled", 32'h1, 32'(st0[8]));
      rd(PPS_REG_STATUS);
      chk("done", 32'h1, 32'(st[11]));
    end
    fs = '{100, 300};
    fe = '{120, 310};
    load(2, 1'b1);
    run(97, 125, 6);
    wr(PPS_REG_MODE, 32'(PPS_MODE_NULL));
    repeat (2) @(posedge i_clk);
    rd(PPS_REG_STATUS);
    chk("null enabled", 32'h0, 32'(st[8]));
    // Host copy rewritten; sequencer copy must not follow
    wr(PPS_REG_INDEX, 32'h0);
    wr(PPS_REG_DATA, 32'h1388);
    wr(PPS_REG_DATA, 32'h1392);
    run(125, 315, 3);
    rd(PPS_REG_STATUS);
    chk("done resumed", 32'h1, 32'(st[11]));
    wr(PPS_REG_COUNT, 32'h0);
    wr(PPS_REG_MODE, 32'(PPS_MODE_LOAD));
    repeat (3) @(posedge i_clk);
    rd(PPS_REG_STATUS);
    chk("done cleared", 32'h0, 32'(st[11]));
    wr(PPS_REG_MODE, 32'(PPS_MODE_NULL));
    wr(PPS_REG_CONFIG, 32'h1);
    wr(PPS_REG_MODE, 32'(PPS_MODE_SETUP));
    repeat (3) @(posedge i_clk);
    wr(PPS_REG_MODE, 32'(PPS_MODE_NULL));
    repeat (2) @(posedge i_clk);
    rd(PPS_REG_STATUS);
    chk("auto copy", 32'h1, 32'(st[12]));
    fs[0] = 100;
    fe[0] = 120;
    load(1, 1'b0);
    // Reverse mid-frame, then two full passes through the repeating frame
    run(97, 110, 3);
    go(97);
    go(125);
    go(97);
    go(125);
    repeat (6) @(posedge i_clk);
    chk("repeat pulses", 32'd15, 32'(npul));
    rd(PPS_REG_STATUS);
    // Status is steady here, so the port must match the register read
    chk("status port", st, 32'(o_status));
    chk("repeat done", 32'h0, 32'(st[11]));
    chk("repeat enabled", 32'h1, 32'(st[8]));
    tally_and_finish();
  end
endmodule : position_pulse_sequencer_test
`default_nettype wire
